// File: verif/tcep_tb.sv
// Self-checking testbench of the timer channel enable and polarity block.
module testbench;
  import tcep_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals and instance
  // ------------------------------------------------------------
  logic clk = 0, rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest, irq;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] ref_prim = 4'h0, ref_comp = 4'h0, ch_in = 4'h0, comp_in = 4'h0;
  logic [3:0] prim_ch_output, comp_ch_output, prim_evt, comp_evt, sel_in;
  int fail_count = 0, n_compared = 0, np, nc;
  always #5 clk = ~clk;
  tcep_top #(.N(4)) tcep_top_i (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ref_prim(ref_prim), .ref_comp(ref_comp),
    .ch_in(ch_in), .comp_in(comp_in), .prim_ch_output(prim_ch_output),
    .comp_ch_output(comp_ch_output), .prim_evt(prim_evt), .comp_evt(comp_evt),
    .sel_in(sel_in), .irq(irq));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // The request is held until waitrequest is seen low, then one edge passes before the next.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 50) begin
      fail_count++;
      report_and_stop();
    end else begin
      @(posedge clk);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Filtered inputs take several cycles, so events are counted over a generous window.
  task automatic tog(input logic v);
    np = 0;
    nc = 0;
    // A pulse counts only when all four channels fire together.
    ch_in <= {4{v}};
    comp_in <= {4{v}};
    repeat (14) begin
      @(posedge clk);
      #1;
      np += int'(prim_evt === 4'hf);
      nc += int'(comp_evt === 4'hf);
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    bus(0, ADDR_CEP, 0);
    chk("cep reset", CEP_RESET, q);
    bus(1, ADDR_CEP, 32'h0000_ffff);
    bus(0, ADDR_CEP, 0);
    chk("cep all set", 32'h0000_ffff, q);
    bus(1, 4'h2, 32'h5);
    bus(0, 4'h2, 0);
    chk("unmapped", 0, q);
    bus(1, ADDR_CFG, 32'h2);
    bus(1, ADDR_CEP, 0);
    bus(0, ADDR_CEP, 0);
    chk("lock 10", 32'haaaa, q);
    bus(1, ADDR_CFG, 32'h3);
    bus(1, ADDR_CEP, 32'h0);
    bus(0, ADDR_CEP, 0);
    chk("lock 11", 32'haaaa, q);
    bus(1, ADDR_CFG, 32'h1);
    bus(1, ADDR_CEP, 32'h0);
    bus(0, ADDR_CEP, 0);
    chk("unlocked", 0, q);
    avs_byteenable <= 4'h1;
    bus(1, ADDR_CEP, 32'h0000_ffff);
    avs_byteenable <= 4'hf;
    bus(0, ADDR_CEP, 0);
    chk("byte lane", 32'h00ff, q);
  endtask
  task automatic t_out();
    for (int c = 0; c < 4; c++) begin
      bus(1, ADDR_CFG, (c < 2) ? 32'hff00 : 32'h0);
      bus(1, ADDR_CEP, c[0] ? 32'hffff : 32'h5555);
      for (int r = 0; r < 2; r++) begin
        ref_prim <= {4{r[0]}};
        ref_comp <= {4{r[0]}};
        idle(3);
        chk("prim out", {28'h0, {4{r[0] ^ c[0]}}}, prim_ch_output);
        chk("comp out", {28'h0, {4{r[0] ^ (c[0] & (c < 2))}}}, comp_ch_output);
      end
    end
    bus(1, ADDR_CEP, 32'h0);
    idle(3);
    chk("disabled out", 0, {prim_ch_output, comp_ch_output});
  endtask
  task automatic t_in();
    int er[4] = '{1, 0, 0, 1};
    int ef[4] = '{0, 1, 0, 1};
    logic [3:0] grp;
    bus(1, ADDR_CFG, 32'hf00f0);
    for (int i = 0; i < 5; i++) begin
      grp = (i == 4) ? 4'ha : {i[1], 1'b1, i[0], 1'b1};
      bus(1, ADDR_CEP, {16'h0, {4{grp}}});
      idle(14);
      tog(1'b1);
      chk("rise evt", (i == 4) ? 0 : er[i], np);
      chk("rise comp evt", (i == 4) ? 0 : er[i], nc);
      chk("sel in", {28'h0, {4{i != 1}}}, {28'h0, sel_in});
      tog(1'b0);
      chk("fall evt", (i == 4) ? 0 : ef[i], np);
      chk("fall comp evt", (i == 4) ? 0 : ef[i], nc);
    end
  endtask
  task automatic t_irq();
    bus(1, ADDR_STAT, 32'hff);
    bus(1, ADDR_MASK, 0);
    bus(1, ADDR_CEP, 32'hf);
    tog(1'b1);
    idle(2);
    chk("masked irq", 0, irq);
    bus(0, ADDR_STAT, 0);
    chk("stat", 32'h11, q);
    bus(1, ADDR_MASK, 32'h1);
    idle(2);
    chk("irq set", 1, irq);
    bus(1, ADDR_STAT, 32'h11);
    idle(2);
    chk("irq clear", 0, irq);
    bus(0, ADDR_STAT, 0);
    chk("stat clear", 0, q);
  endtask
  initial begin
    idle(2);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_out();
    t_in();
    t_irq();
    report_and_stop();
  end
endmodule // testbench

// File: verilog/tcep_chan.sv
// One timer channel: output gating and polarity, input edge selection.
module tcep_chan
  import tcep_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] fld,
  input wire logic in_mode,
  input wire logic comp_in_mode,
  input wire logic [1:0] comp_mode_sel,
  input wire logic ref_prim,
  input wire logic ref_comp,
  input wire logic filt_in,
  input wire logic filt_comp_in,
  output logic prim_out,
  output logic comp_out,
  output logic prim_evt,
  output logic comp_evt,
  output logic sel_in
);
  logic last_r;
  logic clast_r;
  logic [1:0] edge_sel;
  logic rise, fall, crise, cfall, sel_edge, csel_edge;
  assign edge_sel = {fld[BIT_CPOL], fld[BIT_PPOL]};
  // Output drives its active level only when enabled; polarity flips the primary, and the complementary only under CMSEL_OUT_POL.
  assign prim_out = !in_mode && fld[BIT_PEN] && (ref_prim ^ fld[BIT_PPOL]);
  assign comp_out = !comp_in_mode && fld[BIT_CEN] &&
    (comp_mode_sel == CMSEL_OUT_POL ? (ref_comp ^ fld[BIT_CPOL]) : ref_comp);
  assign sel_in = filt_in ^ (edge_sel == EDGE_FALL);
  assign rise = filt_in && !last_r;
  assign fall = !filt_in && last_r;
  assign crise = filt_comp_in && !clast_r;
  assign cfall = !filt_comp_in && clast_r;
  // The reserved code produces no events rather than guessing an edge.
  assign sel_edge = (edge_sel == EDGE_RISE) ? rise : (edge_sel == EDGE_FALL) ? fall :
    (edge_sel == EDGE_BOTH) ? (rise || fall) : 1'b0;
  assign csel_edge = (edge_sel == EDGE_RISE) ? crise : (edge_sel == EDGE_FALL) ? cfall :
    (edge_sel == EDGE_BOTH) ? (crise || cfall) : 1'b0;
  assign prim_evt = in_mode && fld[BIT_PEN] && sel_edge;
  assign comp_evt = comp_in_mode && fld[BIT_CEN] && csel_edge;
  always_ff @(posedge clk) begin
    if (rst) begin
      last_r <= 1'b0;
      clast_r <= 1'b0;
    end else begin
      last_r <= filt_in;
      clast_r <= filt_comp_in;
    end
  end
endmodule : tcep_chan

// File: verilog/tcep_pkg.sv
// Package with register map, field positions and encodings of the channel enable/polarity block.
package tcep_pkg;
  localparam int NUM_CH = 4;
  localparam int CH_STRIDE = 4;
  localparam logic [3:0] ADDR_CEP = 4'h0;
  localparam logic [3:0] ADDR_CFG = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_MASK = 4'hc;
  localparam logic [31:0] CEP_RESET = 32'h0000_0000;
  localparam int BIT_PEN = 0;
  localparam int BIT_PPOL = 1;
  localparam int BIT_CEN = 2;
  localparam int BIT_CPOL = 3;
  localparam logic [15:0] POL_MASK = 16'haaaa;
  localparam logic [1:0] PROTECTION_LEVEL_L2 = 2'h2;
  localparam logic [1:0] PROTECTION_LEVEL_L3 = 2'h3;
  localparam logic [1:0] CMSEL_OUT_POL = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RSVD = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam int CFG_PROTECTION_LEVEL_LSB = 0;
  localparam int CFG_MODE_LSB = 4;
  localparam int CFG_CMSEL_LSB = 8;
  localparam int CFG_CMODE_LSB = 16;
  typedef enum logic [1:0] {
    TCEP_IDLE = 2'b00,
    TCEP_RESP = 2'b01
  } tcep_bus_t;
endpackage : tcep_pkg

// File: verilog/tcep_top.sv
// Four-channel timer enable and polarity control with Avalon-MM register slave.
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module tcep_top
  import tcep_pkg::*;
#(
  parameter int N = NUM_CH
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [N-1:0] ref_prim,
  input wire logic [N-1:0] ref_comp,
  input wire logic [N-1:0] ch_in,
  input wire logic [N-1:0] comp_in,
  output logic [N-1:0] prim_ch_output,
  output logic [N-1:0] comp_ch_output,
  output logic [N-1:0] prim_evt,
  output logic [N-1:0] comp_evt,
  output logic [N-1:0] sel_in,
  output logic irq
);
  // The register layout holds exactly four four-bit channel groups.
  if (N != NUM_CH) begin : g_bad_n
    $error("tcep_top supports exactly four channels");
  end
  // ----------------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------------
  logic [15:0] cep_r, cep_nxt;
  logic [31:0] cfg_r, stat_r, mask_r, rdata_nxt, rdata_r;
  tcep_bus_t st_r;
  logic req, wr_cep, wr_cfg, wr_stat, wr_mask, locked, irq_r;
  logic ack;
  logic wait_r;
  logic [15:0] wmask;
  logic [2*N-1:0] evt_all;
  logic [N-1:0] pout, cout, pev, cev, sin;
  logic [N-1:0] s1_r, s2_r, s3_r, f_r, c1_r, c2_r, c3_r, cf_r;
  assign req = (avs_read || avs_write) && st_r == TCEP_IDLE;
  // Writes land on the edge that also ends the wait, so a held request commits once.
  assign ack = (avs_read || avs_write) && st_r == TCEP_RESP;
  assign wr_cep = ack && avs_write && avs_address == ADDR_CEP;
  assign wr_cfg = ack && avs_write && avs_address == ADDR_CFG;
  assign wr_stat = ack && avs_write && avs_address == ADDR_STAT;
  assign wr_mask = ack && avs_write && avs_address == ADDR_MASK;
  assign locked = cfg_r[CFG_PROTECTION_LEVEL_LSB+:2] == PROTECTION_LEVEL_L3 || cfg_r[CFG_PROTECTION_LEVEL_LSB+:2] == PROTECTION_LEVEL_L2;
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} &
    (locked ? ~POL_MASK : 16'hffff);
  assign cep_nxt = (cep_r & ~wmask) | (avs_writedata[15:0] & wmask);
  // Unmapped addresses read zero and accept writes silently.
  assign rdata_nxt = avs_address == ADDR_CEP ? {16'h0000, cep_r} :
    avs_address == ADDR_CFG ? cfg_r : avs_address == ADDR_STAT ? stat_r :
    avs_address == ADDR_MASK ? mask_r : 32'h0000_0000;
  assign evt_all = {cev, pev};
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= TCEP_IDLE;
      wait_r <= 1'b1;
      cep_r <= CEP_RESET[15:0];
      cfg_r <= 32'h0000_0000;
      mask_r <= 32'h0000_0000;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= !req;
      unique case (st_r)
        TCEP_IDLE: st_r <= req ? TCEP_RESP : TCEP_IDLE;
        TCEP_RESP: st_r <= TCEP_IDLE;
        default: st_r <= TCEP_IDLE;
      endcase
      if (wr_cep) cep_r <= cep_nxt;
      if (wr_cfg) cfg_r <= avs_writedata;
      if (wr_mask) mask_r <= avs_writedata;
      if (req) rdata_r <= rdata_nxt;
    end
  end
  // ----------------------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------------------
  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk) begin
    if (rst) stat_r <= 32'h0000_0000;
    else stat_r <= (stat_r & ~(wr_stat ? avs_writedata : 32'h0)) | {24'h0, evt_all};
  end
  always_ff @(posedge clk) begin
    if (rst) irq_r <= 1'b0;
    else irq_r <= |(stat_r & mask_r);
  end
  // Waitrequest has a flop of its own, so the master never sees a decode glitch.
  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign irq = irq_r;
  // ----------------------------------------------------------------------------
  // Input synchronisers and channels
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      f_r <= '0;
      c1_r <= '0;
      c2_r <= '0;
      c3_r <= '0;
      cf_r <= '0;
    end else begin
      s1_r <= ch_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      f_r <= (s2_r & s3_r) | (f_r & (s2_r | s3_r));
      c1_r <= comp_in;
      c2_r <= c1_r;
      c3_r <= c2_r;
      cf_r <= (c2_r & c3_r) | (cf_r & (c2_r | c3_r));
    end
  end
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      tcep_chan u_ch (
        .clk(clk),
        .rst(rst),
        .fld(cep_r[g*CH_STRIDE+:CH_STRIDE]),
        .in_mode(cfg_r[CFG_MODE_LSB+g]),
        .comp_in_mode(cfg_r[CFG_CMODE_LSB+g]),
        .comp_mode_sel(cfg_r[CFG_CMSEL_LSB+2*g+:2]),
        .ref_prim(ref_prim[g]),
        .ref_comp(ref_comp[g]),
        .filt_in(f_r[g]),
        .filt_comp_in(cf_r[g]),
        .prim_out(pout[g]),
        .comp_out(cout[g]),
        .prim_evt(pev[g]),
        .comp_evt(cev[g]),
        .sel_in(sin[g])
      );
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (rst) begin
      prim_ch_output <= '0;
      comp_ch_output <= '0;
      prim_evt <= '0;
      comp_evt <= '0;
      sel_in <= '0;
    end else begin
      prim_ch_output <= pout;
      comp_ch_output <= cout;
      prim_evt <= pev;
      comp_evt <= cev;
      sel_in <= sin;
    end
  end
  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  a_pol_lock: assert property (@(posedge clk) disable iff (rst)
    locked |=> ((cep_r & POL_MASK) == ($past(cep_r) & POL_MASK)))
    else $error("polarity changed while locked");
  a_upper_zero: assert property (@(posedge clk) disable iff (rst)
    (st_r == TCEP_RESP && $past(avs_address) == ADDR_CEP) |-> avs_readdata[31:16] == 16'h0)
    else $error("reserved bits not zero");
  a_prim_gate: assert property (@(posedge clk) disable iff (rst)
    !cep_r[BIT_PEN] ##1 !cep_r[BIT_PEN] |-> !prim_evt[0] && !prim_ch_output[0])
    else $error("disabled channel zero active");
  a_prim_pol: assert property (@(posedge clk) disable iff (rst)
    (!cfg_r[CFG_MODE_LSB] && cep_r[BIT_PEN]) |=> prim_ch_output[0] ==
      ($past(ref_prim[0]) ^ $past(cep_r[BIT_PPOL])))
    else $error("primary polarity wrong");
  a_comp_pol: assert property (@(posedge clk) disable iff (rst)
    (!cfg_r[CFG_CMODE_LSB] && cep_r[BIT_CEN] && cfg_r[CFG_CMSEL_LSB+:2] == CMSEL_OUT_POL)
      |=> comp_ch_output[0] == ($past(ref_comp[0]) ^ $past(cep_r[BIT_CPOL])))
    else $error("comp polarity wrong");
  a_comp_gate: assert property (@(posedge clk) disable iff (rst)
    !cep_r[BIT_CEN] |=> !comp_ch_output[0] && !comp_evt[0])
    else $error("disabled comp path active");
  a_both_edge: assert property (@(posedge clk) disable iff (rst)
    (cfg_r[CFG_MODE_LSB] && cep_r[BIT_PEN] && cep_r[BIT_CPOL] && cep_r[BIT_PPOL] &&
      $changed(f_r[0])) |=> prim_evt[0])
    else $error("both-edge event missed");
  a_rsvd_edge: assert property (@(posedge clk) disable iff (rst)
    (cep_r[BIT_CPOL] && !cep_r[BIT_PPOL]) |=> !prim_evt[0])
    else $error("reserved edge produced event");
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    |(stat_r & mask_r) |=> irq)
    else $error("interrupt missing");
  a_wait_pulse: assert property (@(posedge clk) disable iff (rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_irq_quiet: assert property (@(posedge clk) disable iff (rst)
    !(|(stat_r & mask_r)) |=> !irq)
    else $error("interrupt without unmasked status");
  a_stat_sticky: assert property (@(posedge clk) disable iff (rst)
    (stat_r[0] && !(wr_stat && avs_writedata[0])) |=> stat_r[0])
    else $error("status bit lost without clear");
  a_fall_invert: assert property (@(posedge clk) disable iff (rst)
    (!cep_r[BIT_CPOL] && cep_r[BIT_PPOL]) |=> sel_in[0] == !$past(f_r[0]))
    else $error("falling edge input not inverted");
  a_chan1_gate: assert property (@(posedge clk) disable iff (rst)
    !cep_r[CH_STRIDE+BIT_PEN] |=> !prim_ch_output[1] && !prim_evt[1])
    else $error("disabled channel one active");
  c_both: cover property (@(posedge clk) disable iff (rst) prim_evt[0] ##[1:20] prim_evt[0]);
  c_lock_write: cover property (@(posedge clk) disable iff (rst) locked && wr_cep);
  c_comp_out: cover property (@(posedge clk) disable iff (rst) comp_ch_output[0]);
  c_irq: cover property (@(posedge clk) disable iff (rst) irq);
  c_chan3: cover property (@(posedge clk) disable iff (rst) comp_evt[3]);
endmodule : tcep_top
